// ==== verilog/acf_pkg.sv ====
package acf_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int NVM_WAIT_MS = 20;
  localparam int NVM_WAIT_CYC = NVM_WAIT_MS * 1000000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // serial frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 13;
  localparam int ADR_MSB = 12;
  localparam int ADR_LSB = 8;
  localparam int DAT_MSB = 7;
  localparam int DAT_LSB = 0;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [4:0] LAST_BIT = 5'hF;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_ZOFF_LO = 5'h00;
  localparam logic [4:0] ADDR_ZOFF_HI = 5'h01;
  localparam logic [4:0] ADDR_THRESH = 5'h06;
  localparam logic [4:0] ADDR_DIR = 5'h09;
  localparam logic [4:0] ADDR_FLAGS = 5'h1B;
  localparam int THR_LOW_MSB = 7;
  localparam int THR_LOW_LSB = 5;
  localparam int THR_HIGH_MSB = 4;
  localparam int THR_HIGH_LSB = 2;
  localparam int DIR_BIT = 7;
  localparam int FLAG_HIGH_BIT = 7;
  localparam int FLAG_LOW_BIT = 6;
  localparam logic [7:0] ZOFF_LO_RST = 8'h00;
  localparam logic [7:0] ZOFF_HI_RST = 8'h00;
  localparam logic [7:0] THRESH_RST = 8'h1C;
  localparam logic DIR_RST = 1'b0;

  // ---------------------------------------------------------------
  // field strength trip points, in mT
  // ---------------------------------------------------------------
  localparam int FIELD_W = 8;
  localparam logic [FIELD_W-1:0] HYST_MT = 8'h06;

  // rising-field trip point of a 3-bit threshold code
  function automatic logic [FIELD_W-1:0] rise_mt(input logic [2:0] code);
    case (code)
      3'h0: rise_mt = 8'h1A;
      3'h1: rise_mt = 8'h29;
      3'h2: rise_mt = 8'h38;
      3'h3: rise_mt = 8'h46;
      3'h4: rise_mt = 8'h54;
      3'h5: rise_mt = 8'h62;
      3'h6: rise_mt = 8'h70;
      default: rise_mt = 8'h7E;
    endcase
  endfunction

  // falling-field trip point sits a fixed hysteresis lower
  function automatic logic [FIELD_W-1:0] fall_mt(input logic [2:0] code);
    fall_mt = rise_mt(code) - HYST_MT;
  endfunction

endpackage

// ==== verilog/acf_field_flags.sv ====
`timescale 1ns/10ps
module acf_field_flags (
  input wire logic clk,
  input wire logic rst,
  input wire logic [acf_pkg::FIELD_W-1:0] field_mt,
  input wire logic [2:0] high_code,
  input wire logic [2:0] low_code,
  output logic high_flag,
  output logic low_flag
);
  import acf_pkg::*;

  typedef struct packed {
    logic high;
    logic low;
  } acf_flag_state_type;

  acf_flag_state_type flag_reg;
  acf_flag_state_type flag_next;

  // ---------------------------------------------------------------
  // comparators with hysteresis
  // ---------------------------------------------------------------
  // codes are used as given, a low code above the high code is legal
  always_comb begin
    flag_next = flag_reg;
    if (field_mt > rise_mt(high_code)) begin
      flag_next.high = 1'b1;
    end else if (field_mt < fall_mt(high_code)) begin
      flag_next.high = 1'b0;
    end
    if (field_mt < fall_mt(low_code)) begin
      flag_next.low = 1'b1;
    end else if (field_mt > rise_mt(low_code)) begin
      flag_next.low = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign high_flag = flag_reg.high;
  assign low_flag = flag_reg.low;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_high_set: assert property (
    field_mt > rise_mt(high_code) |=> high_flag)
    else $error("high flag not set above threshold");
  a_low_set: assert property (
    field_mt < fall_mt(low_code) |=> low_flag)
    else $error("low flag not set below threshold");
  a_high_hyst: assert property (
    (!high_flag && field_mt <= rise_mt(high_code)) |=> !high_flag)
    else $error("high flag set inside hysteresis band");
  c_high_rise: cover property ($rose(high_flag));
  c_low_rise: cover property ($rose(low_flag));
endmodule

// ==== verilog/acf_angle_config.sv ====
`timescale 1ns/10ps
// Operation
// - angle output is raw angle minus zero
// - stored code is complement of zero position
// - zero code resets to zero
// - code low byte reg 0, high reg 1
// - direction bit reverses angle count sense
// - high flag set above high threshold
// - low flag set below low threshold
// - thresholds: low 7..5, high 4..2, reg 6
// - codes map 26..126 mT, 6 mT hysteresis
// - low code above high code accepted
// - flags at bits 7,6 of reg 27
// - flags also driven on two pins
// - next frame returns the register byte
// - read frame: 010, address, eight zeros
// - write frame: 100, address, data; next frame echoes the register, new data only after the store wait
// - direction select is bit 7 of reg 9
module acf_angle_config #(
  parameter int NVM_WAIT = acf_pkg::NVM_WAIT_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic MOSI,
  output logic MISO,
  input wire logic [15:0] RAW_ANGLE,
  input wire logic [acf_pkg::FIELD_W-1:0] FIELD_MT,
  output logic [15:0] ANGLE,
  output logic FIELD_HIGH_FLAG,
  output logic FIELD_LOW_FLAG
);
  import acf_pkg::*;

  localparam int CNT_W = $clog2(NVM_WAIT + 1);

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_n_s;
    logic [2:0] mosi_s;
    logic sclk_l;
    logic cs_n_l;
    logic mosi_l;
    logic [FRAME_BITS-1:0] rx;
    logic [FRAME_BITS-1:0] tx;
    logic [4:0] bit_cnt;
    logic resp_is_reg;
    logic [4:0] resp_addr;
    logic [7:0] zoff_lo;
    logic [7:0] zoff_hi;
    logic [7:0] thresh;
    logic dir;
    logic pend_busy;
    logic [4:0] pend_addr;
    logic [7:0] pend_data;
    logic [CNT_W-1:0] nvm_cnt;
    logic [15:0] angle;
    logic miso;
  } acf_state_type;

  acf_state_type st_reg;
  acf_state_type st_next;
  logic [FRAME_BITS-1:0] word;
  logic [15:0] src_angle;
  logic [7:0] rd_val;
  logic [7:0] flags_val;
  logic [15:0] first_tx;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic frame_start;
  logic frame_done;
  logic commit;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // a pin level counts only once the second and third stage agree
  function automatic logic filt(input logic [2:0] s, input logic lvl);
    filt = (s[1] == s[2]) ? s[2] : lvl;
  endfunction

  // ---------------------------------------------------------------
  // field flags
  // ---------------------------------------------------------------
  acf_field_flags u_flags (
    .clk(CLK),
    .rst(RST),
    .field_mt(FIELD_MT),
    .high_code(st_reg.thresh[THR_HIGH_MSB:THR_HIGH_LSB]),
    .low_code(st_reg.thresh[THR_LOW_MSB:THR_LOW_LSB]),
    .high_flag(FIELD_HIGH_FLAG),
    .low_flag(FIELD_LOW_FLAG)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    frame_start = 1'b0;
    frame_done = 1'b0;
    commit = 1'b0;
    // synchronisers: stage 0 feeds only stage 1
    st_next.sclk_s = {st_reg.sclk_s[1:0], SCLK};
    st_next.cs_n_s = {st_reg.cs_n_s[1:0], CS_N};
    st_next.mosi_s = {st_reg.mosi_s[1:0], MOSI};
    st_next.sclk_l = filt(st_reg.sclk_s, st_reg.sclk_l);
    st_next.cs_n_l = filt(st_reg.cs_n_s, st_reg.cs_n_l);
    st_next.mosi_l = filt(st_reg.mosi_s, st_reg.mosi_l);
    sclk_rise = st_next.sclk_l & ~st_reg.sclk_l;
    sclk_fall = ~st_next.sclk_l & st_reg.sclk_l;
    cs_fall = ~st_next.cs_n_l & st_reg.cs_n_l;
    word = {st_reg.rx[FRAME_BITS-2:0], st_next.mosi_l};

    // direction picks the count sense, then the complement code
    // is added, which equals subtracting the zero position
    src_angle = st_reg.dir ? 16'(~RAW_ANGLE + 16'h0001) : RAW_ANGLE;
    st_next.angle =
      16'(src_angle + {st_reg.zoff_hi, st_reg.zoff_lo});

    // register read mux; unused bits read as zero
    flags_val = 8'h00;
    flags_val[FLAG_HIGH_BIT] = FIELD_HIGH_FLAG;
    flags_val[FLAG_LOW_BIT] = FIELD_LOW_FLAG;
    case (st_reg.resp_addr)
      ADDR_ZOFF_LO: rd_val = st_reg.zoff_lo;
      ADDR_ZOFF_HI: rd_val = st_reg.zoff_hi;
      ADDR_THRESH: rd_val = st_reg.thresh;
      ADDR_DIR: rd_val = {st_reg.dir, 7'h00};
      ADDR_FLAGS: rd_val = flags_val;
      default: rd_val = 8'h00;
    endcase
    first_tx = st_reg.resp_is_reg ? {rd_val, 8'h00} : st_reg.angle;

    // slow store: settings change only when the wait runs out,
    // so a frame sent too early still sees the previous value
    if (st_reg.pend_busy) begin
      if (st_reg.nvm_cnt == '0) begin
        commit = 1'b1;
        st_next.pend_busy = 1'b0;
        case (st_reg.pend_addr)
          ADDR_ZOFF_LO: st_next.zoff_lo = st_reg.pend_data;
          ADDR_ZOFF_HI: st_next.zoff_hi = st_reg.pend_data;
          ADDR_THRESH: st_next.thresh = st_reg.pend_data;
          ADDR_DIR: st_next.dir = st_reg.pend_data[DIR_BIT];
          default: st_next.pend_busy = 1'b0;
        endcase
      end else begin
        st_next.nvm_cnt = CNT_W'(st_reg.nvm_cnt - 1'b1);
      end
    end

    // serial framing, clock idles low, data taken on rising edge
    if (st_next.cs_n_l) begin
      st_next.miso = 1'b0;
      st_next.bit_cnt = 5'h00;
    end else if (cs_fall) begin
      frame_start = 1'b1;
      st_next.tx = first_tx;
      st_next.miso = first_tx[FRAME_BITS-1];
      st_next.bit_cnt = 5'h00;
      st_next.resp_is_reg = 1'b0;
    end else if (sclk_rise) begin
      st_next.rx = word;
      st_next.bit_cnt = 5'(st_reg.bit_cnt + 1'b1);
      if (st_reg.bit_cnt == LAST_BIT) begin
        frame_done = 1'b1;
        st_next.resp_addr = word[ADR_MSB:ADR_LSB];
        case (word[CMD_MSB:CMD_LSB])
          CMD_READ: begin
            st_next.resp_is_reg = 1'b1;
          end
          CMD_WRITE: begin
            st_next.resp_is_reg = 1'b1;
            if (word[ADR_MSB:ADR_LSB] != ADDR_FLAGS) begin
              st_next.pend_busy = 1'b1;
              st_next.pend_addr = word[ADR_MSB:ADR_LSB];
              st_next.pend_data = word[DAT_MSB:DAT_LSB];
              st_next.nvm_cnt = CNT_W'(NVM_WAIT - 1);
            end
          end
          default: st_next.resp_is_reg = 1'b0;
        endcase
      end
    end else if (sclk_fall) begin
      // shift out on the falling edge so data is settled at rise
      st_next.tx = {st_reg.tx[FRAME_BITS-2:0], 1'b0};
      st_next.miso = st_reg.tx[FRAME_BITS-2];
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
      st_reg.sclk_l <= 1'b0;
      st_reg.cs_n_s <= 3'h7;
      st_reg.cs_n_l <= 1'b1;
      st_reg.zoff_lo <= ZOFF_LO_RST;
      st_reg.zoff_hi <= ZOFF_HI_RST;
      st_reg.thresh <= THRESH_RST;
      st_reg.dir <= DIR_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign MISO = st_reg.miso;
  assign ANGLE = st_reg.angle;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_angle_plain: assert property (
    (st_reg.dir == 1'b0 && {st_reg.zoff_hi, st_reg.zoff_lo} == 16'h0000)
    |=> ANGLE == $past(RAW_ANGLE))
    else $error("angle differs from raw with zero offset");
  // any offset: reversed raw plus the complement code, mod 65536
  a_angle_reverse: assert property (
    st_reg.dir
    |=> ANGLE == 16'($past({st_reg.zoff_hi, st_reg.zoff_lo})
                     - $past(RAW_ANGLE)))
    else $error("reversed angle wrong");
  a_angle_wrap: assert property (
    !st_reg.dir
    |=> ANGLE == 16'($past(RAW_ANGLE)
                     + $past({st_reg.zoff_hi, st_reg.zoff_lo})))
    else $error("offset does not wrap");
  a_read_decode: assert property (
    (frame_done && word[CMD_MSB:CMD_LSB] == CMD_READ)
    |=> st_reg.resp_is_reg && st_reg.resp_addr == $past(word[ADR_MSB:ADR_LSB]))
    else $error("read request not latched");
  a_flag_reply: assert property (
    (frame_start && st_reg.resp_is_reg && st_reg.resp_addr == ADDR_FLAGS)
    |=> MISO == $past(FIELD_HIGH_FLAG)
        && st_reg.tx[FRAME_BITS-2] == $past(FIELD_LOW_FLAG))
    else $error("flag register reply wrong");
  a_write_wait: assert property (
    (frame_done && word[CMD_MSB:CMD_LSB] == CMD_WRITE
     && word[ADR_MSB:ADR_LSB] == ADDR_THRESH)
    |=> (st_reg.pend_busy && $stable(st_reg.thresh)) [*8])
    else $error("setting changed before store wait");
  a_write_commit: assert property (
    (commit && st_reg.pend_addr == ADDR_DIR)
    |=> st_reg.dir == $past(st_reg.pend_data[DIR_BIT]) && !st_reg.pend_busy)
    else $error("direction write not applied");
  a_bit_count: assert property (
    frame_done |=> st_reg.bit_cnt == 5'h10)
    else $error("frame ended at wrong bit");
  // settings come out of reset at their defaults
  a_reset_values: assert property (
    $fell(RST)
    |-> {st_reg.zoff_hi, st_reg.zoff_lo} == {ZOFF_HI_RST, ZOFF_LO_RST}
        && st_reg.thresh == THRESH_RST && st_reg.dir == DIR_RST)
    else $error("settings not at defaults after reset");
  // each store lands in the byte that its address names
  a_zoff_lo_commit: assert property (
    (commit && st_reg.pend_addr == ADDR_ZOFF_LO)
    |=> st_reg.zoff_lo == $past(st_reg.pend_data))
    else $error("zero code low byte not stored");
  a_zoff_hi_commit: assert property (
    (commit && st_reg.pend_addr == ADDR_ZOFF_HI)
    |=> st_reg.zoff_hi == $past(st_reg.pend_data))
    else $error("zero code high byte not stored");
  a_thresh_commit: assert property (
    (commit && st_reg.pend_addr == ADDR_THRESH)
    |=> st_reg.thresh == $past(st_reg.pend_data))
    else $error("threshold byte not stored");
  // reply framing: bytes and padding of the answer word, and no store started by a read
  a_flag_pad: assert property (
    (frame_start && st_reg.resp_is_reg && st_reg.resp_addr == ADDR_FLAGS)
    |=> st_reg.tx[FRAME_BITS-3:0] == '0)
    else $error("flag register spare bits not zero");
  a_echo_value: assert property (
    (frame_start && st_reg.resp_is_reg && st_reg.resp_addr == ADDR_THRESH)
    |=> st_reg.tx[FRAME_BITS-1:FRAME_BITS-8] == $past(st_reg.thresh))
    else $error("threshold echo wrong");
  a_read_no_store: assert property (
    (frame_done && word[CMD_MSB:CMD_LSB] == CMD_READ && !st_reg.pend_busy)
    |=> !st_reg.pend_busy)
    else $error("read request started a store");
  // a deselected link never shows stale reply bits
  a_miso_idle: assert property (
    (st_reg.cs_n_l && st_reg.cs_n_s[2:1] == 2'h3) |=> !MISO)
    else $error("reply driven outside a frame");
  c_flag_read: cover property (
    frame_start && st_reg.resp_is_reg && st_reg.resp_addr == ADDR_FLAGS);
  c_commit: cover property (commit);
  c_write: cover property (frame_done && word[CMD_MSB:CMD_LSB] == CMD_WRITE);
endmodule

// ==== bench/acf_spi_host.sv ====
`timescale 1ns/10ps
// -------------------------------------------------------------
// host side of the serial link, one 16-bit frame per go pulse
// -------------------------------------------------------------
module acf_spi_host (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] tx_word,
  output logic busy,
  output logic [15:0] rx_word,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  localparam realtime HALF = 62.5;

  // mode 0, msb first; the clock stands low outside frames
  initial begin
    busy = 1'b0;
    rx_word = 16'h0000;
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    forever begin
      @(posedge clk iff go);
      busy = 1'b1;
      #3;
      cs_n = 1'b0;
      // command, address, then data or zeros, bit 15 first
      for (int i = 15; i >= 0; i--) begin
        mosi = tx_word[i];
        #HALF;
        sclk = 1'b1;
        rx_word[i] = miso;
        #HALF;
        sclk = 1'b0;
      end
      #HALF;
      cs_n = 1'b1;
      // released data line must not keep showing the last bit
      mosi = ~mosi;
      #100;
      busy = 1'b0;
    end
  end
endmodule

// ==== bench/acf_angle_config_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
  end \
end

module acf_angle_config_tb_top;
  import acf_pkg::*;
  // short store wait keeps the run small
  localparam int WAIT_CYC = 50;
  logic clk, rst, sclk, cs_n, mosi, miso, go, busy, hi_pin, lo_pin;
  logic [15:0] raw, angle, tx, rx;
  logic [FIELD_W-1:0] field;
  logic [7:0] rd;
  int bad_count = 0;
  int checks = 0;
  logic [4:0] ra [5] = '{5'h00, 5'h01, 5'h06, 5'h09, 5'h05};
  logic [7:0] re [5] = '{8'h00, 8'h00, 8'h1C, 8'h00, 8'h00};
  logic [7:0] rise [8] = '{8'h1A, 8'h29, 8'h38, 8'h46, 8'h54, 8'h62,
                          8'h70, 8'h7E};

  // -----------------------------------------------------------
  // design and host
  // -----------------------------------------------------------
  acf_angle_config #(.NVM_WAIT(WAIT_CYC)) DUT (
    .CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi),
    .MISO(miso), .RAW_ANGLE(raw), .FIELD_MT(field), .ANGLE(angle),
    .FIELD_HIGH_FLAG(hi_pin), .FIELD_LOW_FLAG(lo_pin)
  );
  acf_spi_host host (
    .clk(clk), .go(go), .tx_word(tx), .busy(busy), .rx_word(rx),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // -----------------------------------------------------------
  // tasks
  // -----------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one frame; the wait is bounded so a stuck host ends the run
  task automatic frame(input logic [15:0] w);
    int n;
    @(posedge clk);
    tx <= w;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    n = 0;
    while (busy === 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000) begin
      bad_count++;
      end_of_test();
    end
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [7:0] v);
    frame({CMD_READ, a, 8'h00});
    frame(16'h0000);
    v = rx[15:8];
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    frame({CMD_WRITE, a, d});
    repeat (WAIT_CYC + 10) @(posedge clk);
    frame(16'h0000);
    `CHK("write echo", d, rx[15:8])
  endtask

  task automatic drive(input logic [15:0] r, input logic [7:0] f);
    @(posedge clk);
    raw <= r;
    field <= f;
    repeat (8) @(posedge clk);
  endtask

  task automatic pins(input logic h, input logic l);
    `CHK("high pin", h, hi_pin)
    `CHK("low pin", l, lo_pin)
  endtask

  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial begin
    rst = 1'b1;
    go = 1'b0;
    tx = 16'h0000;
    raw = 16'h1234;
    field = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("angle no offset", 16'h1234, angle)
    for (int i = 0; i < 5; i++) begin
      rd_reg(ra[i], rd);
      `CHK("reset value", re[i], rd)
    end
    // complement code for a 20 degree zero position
    wr_reg(ADDR_ZOFF_LO, 8'hC7);
    wr_reg(ADDR_ZOFF_HI, 8'hF1);
    drive(16'h0E39, 8'h00);
    `CHK("angle at zero", 16'h0000, angle)
    drive(16'h1000, 8'h00);
    `CHK("angle wrap", 16'h01C7, angle)
    // reply before the store completes still carries the old value
    frame({CMD_WRITE, ADDR_DIR, 8'h80});
    frame(16'h0000);
    `CHK("early echo", 8'h00, rx[15:8])
    repeat (WAIT_CYC + 10) @(posedge clk);
    rd_reg(ADDR_DIR, rd);
    `CHK("direction reg", 8'h80, rd)
    drive(16'h0E39, 8'h00);
    `CHK("angle reversed", 16'hE38E, angle)
    // every threshold code: trip, hysteresis band, release
    for (int c = 0; c < 8; c++) begin
      wr_reg(ADDR_THRESH, {3'(c), 3'(c), 2'h0});
      drive(raw, rise[c] + 8'h01);
      pins(1'b1, 1'b0);
      rd_reg(ADDR_FLAGS, rd);
      `CHK("flag reg high", 8'h80, rd)
      drive(raw, rise[c] - 8'h03);
      pins(1'b1, 1'b0);
      drive(raw, rise[c] - 8'h07);
      pins(1'b0, 1'b1);
      rd_reg(ADDR_FLAGS, rd);
      `CHK("flag reg low", 8'h40, rd)
      drive(raw, rise[c] - 8'h03);
      pins(1'b0, 1'b1);
    end
    // low code above high code is kept as written
    wr_reg(ADDR_THRESH, 8'hE0);
    drive(raw, 8'h64);
    pins(1'b1, 1'b1);
    end_of_test();
  end
endmodule
